/* fpt_pkg.sv */
// Constants, types and register map of the flash protection and timing controller
`default_nettype none
package fpt_pkg;
    // Register byte offsets
    localparam logic [8:0]  OFS_TARGET  = 9'h000;
    localparam logic [8:0]  OFS_WORD    = 9'h004;
    localparam logic [8:0]  OFS_CMD     = 9'h008;
    localparam logic [8:0]  OFS_STATUS  = 9'h00C;
    localparam logic [8:0]  OFS_MASK    = 9'h010;
    localparam logic [8:0]  OFS_MSTATUS = 9'h014;
    localparam logic [8:0]  OFS_READEN  = 9'h130;
    localparam logic [8:0]  OFS_PROGEN  = 9'h134;
    localparam logic [8:0]  OFS_USEC    = 9'h140;

    // Array geometry
    localparam int          MEM_AW      = 14;
    localparam int          MEM_DEPTH   = 8194;
    localparam int          BLOCKS      = 16;
    localparam logic [13:0] PAGE_WORDS  = 14'h0100;
    localparam logic [13:0] ARRAY_WORDS = 14'h2000;
    localparam logic [13:0] ROW_READEN  = 14'h2000;
    localparam logic [13:0] ROW_PROGEN  = 14'h2001;
    localparam logic [31:0] ERASED_WORD = 32'hFFFFFFFF;

    // Command register
    localparam logic [15:0] CMD_KEY     = 16'hA442;
    localparam int          CMD_PROG    = 0;
    localparam int          CMD_ERASE   = 1;
    localparam int          CMD_MASS    = 2;
    localparam int          CMD_COMMIT  = 3;

    // Status and mask bit positions
    localparam int          ST_ACCESS   = 0;
    localparam int          ST_DONE     = 1;
    localparam int          ST_READ     = 2;

    // Reset values
    localparam logic [7:0]  USEC_RESET  = 8'h31;
    localparam logic [15:0] PROT_RESET  = 16'hFFFF;

    // Operation times in microseconds
    localparam logic [15:0] PROG_TIME_US  = 16'h0014;
    localparam logic [15:0] ERASE_TIME_US = 16'h4E20;

    typedef enum logic [2:0] {
        S_BOOT0  = 3'h0,
        S_BOOT1  = 3'h1,
        S_BOOT2  = 3'h2,
        S_IDLE   = 3'h3,
        S_PROG   = 3'h4,
        S_FILL   = 3'h5,
        S_WAIT   = 3'h6,
        S_COMMIT = 3'h7
    } fpt_state_t;

    typedef struct packed {
        fpt_state_t  state;
        logic [31:0] targetAddr;
        logic [31:0] writeWord;
        logic [3:0]  cmd;
        logic [2:0]  status;
        logic [2:0]  mask;
        logic [15:0] readEn;
        logic [15:0] progEn;
        logic [7:0]  usecReload;
        logic [7:0]  usecCnt;
        logic [15:0] usCnt;
        logic [13:0] fillAddr;
        logic [13:0] fillLeft;
        logic        ack;
        logic [31:0] rdata;
        logic        fetchValid;
        logic        fetchDenied;
    } fpt_regs_t;

    localparam fpt_regs_t REGS_RESET = '{
        state: S_BOOT0, targetAddr: 32'h0, writeWord: 32'h0, cmd: 4'h0,
        status: 3'h0, mask: 3'h0, readEn: 16'h0, progEn: 16'h0,
        usecReload: USEC_RESET, usecCnt: 8'h0, usCnt: 16'h0,
        fillAddr: 14'h0, fillLeft: 14'h0, ack: 1'b0, rdata: 32'h0,
        fetchValid: 1'b0, fetchDenied: 1'b0
    };
endpackage
`default_nettype wire

/* fpt_mem_if.sv */
// Port bundle between controller and flash array
`default_nettype none
interface fpt_mem_if;
    logic        en;
    logic        we;
    logic        rdZero;
    logic [13:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    modport ctrl (output en, output we, output rdZero, output addr, output wdata, input rdata);
    modport mem  (input en, input we, input rdZero, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

/* fpt_flash_mem.sv */
// Flash array with protection rows, registered read data
`default_nettype none
module fpt_flash_mem (
    input  wire logic  ref_clk,
    fpt_mem_if.mem     bus
);
    logic [31:0] cells [0:fpt_pkg::MEM_DEPTH-1];

    // Factory state: every word erased, every protection bit one
    initial begin
        for (int i = 0; i < fpt_pkg::MEM_DEPTH; i++) begin
            cells[i] = fpt_pkg::ERASED_WORD;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (bus.en) begin
            if (bus.we) begin
                cells[bus.addr] <= bus.wdata;
            end
            bus.rdata <= bus.rdZero ? 32'h00000000 : cells[bus.addr];
        end
    end
endmodule
`default_nettype wire

/* flash_protect_timing_ctrl.sv */
// Flash controller: protection policy, commit, program/erase timing, Avalon-MM registers
//
// Notes on behaviour
// - Array is 1 KB pages, each erasable alone
// - Finished page erase leaves all ones
// - Two pages form one 2 KB protection block
// - Program or erase only with program-enable set
// - Read-enable clear: fetches only, data reads refused
// - Program-enable set, read-enable clear: write, no data reads
// - Refused program/erase raises masked access interrupt
// - Refused data read returns zeros, optional interrupt
// - Protection bits only clear, never set
// - Clears act now, survive reset only committed
// - Operation timing from microsecond reload value
// - Reload resets to default, software updates
// - Page erase and mass erase via registers
`default_nettype none
module flash_protect_timing_ctrl #(
    parameter logic [15:0] PROG_TIME_US  = fpt_pkg::PROG_TIME_US,
    parameter logic [15:0] ERASE_TIME_US = fpt_pkg::ERASE_TIME_US
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [8:0]  avsAddress,
    input  wire logic        avsRead,
    input  wire logic        avsWrite,
    input  wire logic [3:0]  avsByteEnable,
    input  wire logic [31:0] avsWriteData,
    output logic [31:0]      avsReadData,
    output logic             avsWaitrequest,
    input  wire logic        fetchReq,
    input  wire logic        fetchIsData,
    input  wire logic [14:0] fetchAddr,
    output logic             fetchReady,
    output logic             fetchValid,
    output logic             fetchDenied,
    output logic [31:0]      fetchRdata,
    output logic             irq
);
    fpt_pkg::fpt_regs_t q;
    fpt_pkg::fpt_regs_t r;
    fpt_mem_if          memBus ();

    logic        access;
    logic        take;
    logic        cmdWrite;
    logic [2:0]  setBits;
    logic [2:0]  clrBits;
    logic [3:0]  blk;
    logic [3:0]  fetchBlk;
    logic        deny;
    logic        tick;
    logic [31:0] merged;

    // Byte-lane merge of a write into an old value
    function automatic logic [31:0] applyBe(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // 2 KB block number of a byte address
    function automatic logic [3:0] blockOf(input logic [14:0] a);
        return a[14:11];
    endfunction

    fpt_flash_mem uMem (
        .ref_clk (ref_clk),
        .bus     (memBus.mem)
    );

    assign access         = avsRead | avsWrite;
    assign take           = access & q.ack;
    assign avsWaitrequest = access & ~q.ack;
    assign avsReadData    = q.rdata;
    assign fetchReady     = (q.state == fpt_pkg::S_IDLE);
    assign fetchValid     = q.fetchValid;
    assign fetchDenied    = q.fetchDenied;
    assign fetchRdata     = memBus.rdata;
    assign irq            = |(q.status & q.mask);

    always_comb begin
        r             = q;
        setBits       = 3'h0;
        clrBits       = 3'h0;
        memBus.en     = 1'b0;
        memBus.we     = 1'b0;
        memBus.rdZero = 1'b0;
        memBus.addr   = 14'h0;
        memBus.wdata  = 32'h0;
        blk           = blockOf(q.targetAddr[14:0]);
        fetchBlk      = blockOf(fetchAddr);
        deny          = fetchIsData & ~q.readEn[fetchBlk];
        tick          = (q.usecCnt == 8'h00);
        merged        = applyBe(32'h0, avsWriteData, avsByteEnable);
        cmdWrite      = take & avsWrite & (avsAddress == fpt_pkg::OFS_CMD)
                        & (avsWriteData[31:16] == fpt_pkg::CMD_KEY);
        r.ack         = access & ~q.ack;
        r.fetchValid  = 1'b0;

        // Read data captured one cycle ahead of the accepting edge
        if (access & ~q.ack) begin
            unique case (avsAddress)
                fpt_pkg::OFS_TARGET:  r.rdata = q.targetAddr;
                fpt_pkg::OFS_WORD:    r.rdata = q.writeWord;
                fpt_pkg::OFS_CMD:     r.rdata = {28'h0, q.cmd};
                fpt_pkg::OFS_STATUS:  r.rdata = {29'h0, q.status};
                fpt_pkg::OFS_MASK:    r.rdata = {29'h0, q.mask};
                fpt_pkg::OFS_MSTATUS: r.rdata = {29'h0, q.status & q.mask};
                fpt_pkg::OFS_READEN:  r.rdata = {16'h0, q.readEn};
                fpt_pkg::OFS_PROGEN:  r.rdata = {16'h0, q.progEn};
                fpt_pkg::OFS_USEC:    r.rdata = {24'h0, q.usecReload};
                default:              r.rdata = 32'h0;
            endcase
        end

        // Plain register writes
        if (take & avsWrite) begin
            unique case (avsAddress)
                fpt_pkg::OFS_TARGET: r.targetAddr = applyBe(q.targetAddr, avsWriteData,
                                                            avsByteEnable);
                fpt_pkg::OFS_WORD:   r.writeWord  = applyBe(q.writeWord, avsWriteData,
                                                            avsByteEnable);
                fpt_pkg::OFS_MASK:   r.mask       = applyBe({29'h0, q.mask}, avsWriteData,
                                                            avsByteEnable)[2:0];
                fpt_pkg::OFS_READEN: r.readEn     = q.readEn
                                                    & applyBe({16'h0, q.readEn}, avsWriteData,
                                                              avsByteEnable)[15:0];
                fpt_pkg::OFS_PROGEN: r.progEn     = q.progEn
                                                    & applyBe({16'h0, q.progEn}, avsWriteData,
                                                              avsByteEnable)[15:0];
                fpt_pkg::OFS_USEC:   r.usecReload = applyBe({24'h0, q.usecReload},
                                                            avsWriteData,
                                                            avsByteEnable)[7:0];
                default:             r.rdata      = r.rdata;
            endcase
        end

        unique case (q.state)
            // Volatile protection bits reloaded from committed rows after reset
            fpt_pkg::S_BOOT0: begin
                memBus.en   = 1'b1;
                memBus.addr = fpt_pkg::ROW_READEN;
                r.state     = fpt_pkg::S_BOOT1;
            end
            fpt_pkg::S_BOOT1: begin
                r.readEn    = memBus.rdata[15:0];
                memBus.en   = 1'b1;
                memBus.addr = fpt_pkg::ROW_PROGEN;
                r.state     = fpt_pkg::S_BOOT2;
            end
            fpt_pkg::S_BOOT2: begin
                r.progEn = memBus.rdata[15:0];
                r.state  = fpt_pkg::S_IDLE;
            end
            fpt_pkg::S_IDLE: begin
                if (fetchReq) begin
                    memBus.en     = 1'b1;
                    memBus.addr   = {1'b0, fetchAddr[14:2]};
                    memBus.rdZero = deny;
                    r.fetchValid  = 1'b1;
                    r.fetchDenied = deny;
                    setBits[fpt_pkg::ST_READ] = deny;
                end
                r.usecCnt = q.usecReload;
                if (cmdWrite) begin
                    if (avsWriteData[fpt_pkg::CMD_COMMIT]) begin
                        r.cmd   = 4'h8;
                        r.state = fpt_pkg::S_COMMIT;
                    end else if (avsWriteData[fpt_pkg::CMD_PROG]) begin
                        if (q.progEn[blk]) begin
                            r.cmd   = 4'h1;
                            r.usCnt = PROG_TIME_US;
                            r.state = fpt_pkg::S_PROG;
                        end else begin
                            setBits[fpt_pkg::ST_ACCESS] = 1'b1;
                        end
                    end else if (avsWriteData[fpt_pkg::CMD_ERASE]) begin
                        if (q.progEn[blk]) begin
                            r.cmd      = 4'h2;
                            r.fillAddr = {1'b0, q.targetAddr[14:10], 8'h00};
                            r.fillLeft = fpt_pkg::PAGE_WORDS;
                            r.state    = fpt_pkg::S_FILL;
                        end else begin
                            setBits[fpt_pkg::ST_ACCESS] = 1'b1;
                        end
                    end else if (avsWriteData[fpt_pkg::CMD_MASS]) begin
                        if (&q.progEn) begin
                            r.cmd      = 4'h4;
                            r.fillAddr = 14'h0;
                            r.fillLeft = fpt_pkg::ARRAY_WORDS;
                            r.state    = fpt_pkg::S_FILL;
                        end else begin
                            setBits[fpt_pkg::ST_ACCESS] = 1'b1;
                        end
                    end
                end
            end
            fpt_pkg::S_FILL: begin
                memBus.en    = 1'b1;
                memBus.we    = 1'b1;
                memBus.addr  = q.fillAddr;
                memBus.wdata = fpt_pkg::ERASED_WORD;
                r.fillAddr   = q.fillAddr + 14'h1;
                r.fillLeft   = q.fillLeft - 14'h1;
                if (q.fillLeft == 14'h1) begin
                    r.usCnt   = ERASE_TIME_US;
                    r.usecCnt = q.usecReload;
                    r.state   = fpt_pkg::S_WAIT;
                end
            end
            fpt_pkg::S_PROG, fpt_pkg::S_WAIT: begin
                // Microsecond tick divider paces the operation
                if (tick) begin
                    r.usecCnt = q.usecReload;
                    r.usCnt   = q.usCnt - 16'h1;
                    if (q.usCnt <= 16'h1) begin
                        if (q.state == fpt_pkg::S_PROG) begin
                            memBus.en    = 1'b1;
                            memBus.we    = 1'b1;
                            memBus.addr  = {1'b0, q.targetAddr[14:2]};
                            memBus.wdata = q.writeWord;
                        end
                        r.cmd   = 4'h0;
                        r.state = fpt_pkg::S_IDLE;
                        setBits[fpt_pkg::ST_DONE] = 1'b1;
                    end
                end else begin
                    r.usecCnt = q.usecCnt - 8'h1;
                end
            end
            fpt_pkg::S_COMMIT: begin
                memBus.en   = 1'b1;
                memBus.we   = 1'b1;
                memBus.addr = q.targetAddr[0] ? fpt_pkg::ROW_PROGEN
                                              : fpt_pkg::ROW_READEN;
                memBus.wdata = {fpt_pkg::PROT_RESET,
                                q.targetAddr[0] ? q.progEn : q.readEn};
                r.cmd   = 4'h0;
                r.state = fpt_pkg::S_IDLE;
                setBits[fpt_pkg::ST_DONE] = 1'b1;
            end
        endcase

        // Status read clears only the bits that were reported; new events win
        if (take & avsRead & (avsAddress == fpt_pkg::OFS_STATUS)) begin
            clrBits = q.rdata[2:0];
        end
        r.status = (q.status & ~clrBits) | setBits;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            q <= fpt_pkg::REGS_RESET;
        end else begin
            q <= r;
        end
    end
endmodule
`default_nettype wire

/* fpt_monitor.sv */
// Port assertions for the flash protection and timing controller
`default_nettype none
module fpt_monitor #(
    parameter logic [15:0] PROG_TIME_US  = fpt_pkg::PROG_TIME_US,
    parameter logic [15:0] ERASE_TIME_US = fpt_pkg::ERASE_TIME_US
) (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic [8:0]  avsAddress,
    input wire logic        avsRead,
    input wire logic        avsWrite,
    input wire logic        avsWaitrequest,
    input wire logic [31:0] avsReadData,
    input wire logic        fetchReq,
    input wire logic        fetchIsData,
    input wire logic        fetchReady,
    input wire logic        fetchValid,
    input wire logic        fetchDenied,
    input wire logic [31:0] fetchRdata,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire logic req = avsRead | avsWrite;
    wire logic done = req & ~avsWaitrequest;
    chk_wait_first: assert property ($rose(req) |-> avsWaitrequest)
        else $error("access answered without a wait cycle");
    chk_wait_one: assert property (req && avsWaitrequest |=> !avsWaitrequest)
        else $error("access not answered after one wait cycle");
    chk_wait_idle: assert property (!req |-> !avsWaitrequest)
        else $error("waitrequest high with no access");
    chk_fetch_answer: assert property (fetchReq && fetchReady |=> fetchValid)
        else $error("taken fetch not answered next cycle");
    chk_valid_cause: assert property (fetchValid |-> $past(fetchReq && fetchReady))
        else $error("fetch answer without a taken request");
    chk_denied_zero: assert property (fetchValid && fetchDenied |-> fetchRdata == 32'h0)
        else $error("refused read returned nonzero data");
    chk_instr_open: assert property (fetchValid && $past(!fetchIsData) |-> !fetchDenied)
        else $error("instruction fetch refused");
    chk_irq_fall: assert property ($fell(irq) |->
        $past(done && (avsAddress == fpt_pkg::OFS_STATUS || avsAddress == fpt_pkg::OFS_MASK)))
        else $error("interrupt dropped without status read or mask write");
    cov_irq: cover property ($rose(irq));
    cov_denied: cover property (fetchValid && fetchDenied);
    cov_write: cover property (avsWrite && !avsWaitrequest);
endmodule
bind flash_protect_timing_ctrl fpt_monitor #(
    .PROG_TIME_US(PROG_TIME_US), .ERASE_TIME_US(ERASE_TIME_US)) u_mon (
    .ref_clk(ref_clk), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWaitrequest(avsWaitrequest), .avsReadData(avsReadData),
    .fetchReq(fetchReq), .fetchIsData(fetchIsData), .fetchReady(fetchReady),
    .fetchValid(fetchValid), .fetchDenied(fetchDenied), .fetchRdata(fetchRdata), .irq(irq));
`default_nettype wire

/* fpt_core_model.sv */
// Processor-side fetch master for the flash read port
`default_nettype none
module fpt_core_model (
    input wire logic        ref_clk,
    input wire logic        fetchReady,
    input wire logic        fetchValid,
    input wire logic        fetchDenied,
    input wire logic [31:0] fetchRdata,
    output logic            fetchReq,
    output logic            fetchIsData,
    output logic [14:0]     fetchAddr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        fetchReq = 1'b0;
        fetchIsData = 1'b0;
        fetchAddr = 15'h0000;
    end
    task automatic fetch(input logic isData, input logic [14:0] a, input int gap,
                         output logic [31:0] d, output logic den, output logic ok);
        int i;
        repeat (gap) @(posedge ref_clk);
        @(posedge ref_clk);
        fetchReq <= 1'b1;
        fetchIsData <= isData;
        fetchAddr <= a;
        for (i = 0; i < 50; i++) begin
            @(negedge ref_clk);
            if (fetchReady === 1'b1) break;
        end
        @(posedge ref_clk);
        fetchReq <= 1'b0;
        fetchAddr <= ~a;
        @(negedge ref_clk);
        ok = (i < 50) && (fetchValid === 1'b1);
        d = fetchRdata;
        den = fetchDenied;
    endtask
endmodule
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the flash protection and timing controller
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, a, b); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'b0, rst = 1'b1, avsRead = 1'b0, avsWrite = 1'b0;
    logic [8:0]  avsAddress = 9'h000;
    logic [31:0] avsWriteData = 32'h0, avsReadData, fetchRdata, rd, word;
    logic        avsWaitrequest, fetchReq, fetchIsData, fetchReady;
    logic        fetchValid, fetchDenied, irq, den;
    logic [14:0] fetchAddr;
    int          err_total = 0, n_checks = 0;
    always #20 ref_clk = ~ref_clk;
    flash_protect_timing_ctrl #(.PROG_TIME_US(16'h0002), .ERASE_TIME_US(16'h0003)) dut (
        .ref_clk(ref_clk), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead),
        .avsWrite(avsWrite), .avsByteEnable(4'hF), .avsWriteData(avsWriteData),
        .avsReadData(avsReadData), .avsWaitrequest(avsWaitrequest), .fetchReq(fetchReq),
        .fetchIsData(fetchIsData), .fetchAddr(fetchAddr), .fetchReady(fetchReady),
        .fetchValid(fetchValid), .fetchDenied(fetchDenied), .fetchRdata(fetchRdata), .irq(irq));
    fpt_core_model core (
        .ref_clk(ref_clk), .fetchReady(fetchReady), .fetchValid(fetchValid),
        .fetchDenied(fetchDenied), .fetchRdata(fetchRdata), .fetchReq(fetchReq),
        .fetchIsData(fetchIsData), .fetchAddr(fetchAddr));
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic acc(input logic w, input logic [8:0] a, input logic [31:0] d);
        int i;
        @(posedge ref_clk);
        avsAddress <= a;
        avsWrite <= w;
        avsRead <= !w;
        avsWriteData <= d;
        for (i = 0; i < 20; i++) begin
            @(negedge ref_clk);
            if (avsWaitrequest === 1'b0) break;
        end
        if (i == 20) begin err_total++; conclude(); end
        rd = avsReadData;
        @(posedge ref_clk);
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
    endtask
    task automatic wr(input logic [8:0] a, input logic [31:0] d); acc(1'b1, a, d); endtask
    task automatic rchk(input logic [8:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask
    task automatic run_cmd(input logic [3:0] c);
        int i;
        wr(fpt_pkg::OFS_CMD, {fpt_pkg::CMD_KEY, 12'h000, c});
        for (i = 0; i < 5000; i++) begin
            acc(1'b0, fpt_pkg::OFS_CMD, 32'h0);
            if (rd[3:0] === 4'h0) break;
        end
        if (i == 5000) begin err_total++; conclude(); end
    endtask
    task automatic prog(input logic [31:0] a, input logic [31:0] d);
        wr(fpt_pkg::OFS_WORD, d);
        wr(fpt_pkg::OFS_TARGET, a);
        run_cmd(4'h1);
    endtask
    task automatic fchk(input logic isD, input logic [14:0] a, input logic [31:0] e,
                        input logic eDen);
        logic ok;
        core.fetch(isD, a, int'(a[3:2]), word, den, ok);
        `CHK(ok, 1'b1)
        `CHK(word, e)
        `CHK(den, eDen)
    endtask
    task automatic do_reset();
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask
    task automatic s_reset_values();
        rchk(fpt_pkg::OFS_PROGEN, 32'h0000FFFF);
        rchk(fpt_pkg::OFS_READEN, 32'h0000FFFF);
        rchk(fpt_pkg::OFS_USEC, 32'h00000031);
        rchk(9'h0FC, 32'h00000000);
        wr(fpt_pkg::OFS_USEC, 32'h00000001);
        rchk(fpt_pkg::OFS_USEC, 32'h00000001);
    endtask
    task automatic s_program_erase();
        prog(32'h0000, 32'h12345678);
        prog(32'h0400, 32'hCAFEF00D);
        fchk(1'b1, 15'h0000, 32'h12345678, 1'b0);
        rchk(fpt_pkg::OFS_STATUS, 32'h00000002);
        wr(fpt_pkg::OFS_TARGET, 32'h0000);
        run_cmd(4'h2);
        fchk(1'b1, 15'h0000, 32'hFFFFFFFF, 1'b0);
        fchk(1'b1, 15'h03FC, 32'hFFFFFFFF, 1'b0);
        fchk(1'b1, 15'h0400, 32'hCAFEF00D, 1'b0);
    endtask
    task automatic s_prog_protect();
        wr(fpt_pkg::OFS_PROGEN, 32'h0000FFFE);
        wr(fpt_pkg::OFS_PROGEN, 32'h0000FFFF);
        rchk(fpt_pkg::OFS_PROGEN, 32'h0000FFFE);
        prog(32'h0000, 32'h0BADBEEF);
        wr(fpt_pkg::OFS_TARGET, 32'h0400);
        run_cmd(4'h2);
        run_cmd(4'h4);
        fchk(1'b1, 15'h0000, 32'hFFFFFFFF, 1'b0);
        fchk(1'b1, 15'h0400, 32'hCAFEF00D, 1'b0);
        `CHK(irq, 1'b0)
        wr(fpt_pkg::OFS_MASK, 32'h00000001);
        @(negedge ref_clk);
        `CHK(irq, 1'b1)
        rchk(fpt_pkg::OFS_MSTATUS, 32'h00000001);
        rchk(fpt_pkg::OFS_STATUS, 32'h00000003);
        @(negedge ref_clk);
        `CHK(irq, 1'b0)
        wr(fpt_pkg::OFS_MASK, 32'h00000000);
    endtask
    task automatic s_read_protect();
        wr(fpt_pkg::OFS_READEN, 32'h0000FFFD);
        prog(32'h0800, 32'h5A5A1234);
        fchk(1'b1, 15'h0800, 32'h00000000, 1'b1);
        fchk(1'b0, 15'h0800, 32'h5A5A1234, 1'b0);
        fchk(1'b1, 15'h0400, 32'hCAFEF00D, 1'b0);
        rchk(fpt_pkg::OFS_STATUS, 32'h00000006);
    endtask
    task automatic s_commit();
        wr(fpt_pkg::OFS_TARGET, 32'h0000);
        run_cmd(4'h8);
        do_reset();
        rchk(fpt_pkg::OFS_READEN, 32'h0000FFFD);
        rchk(fpt_pkg::OFS_PROGEN, 32'h0000FFFF);
        rchk(fpt_pkg::OFS_USEC, 32'h00000031);
        wr(fpt_pkg::OFS_USEC, 32'h00000001);
        run_cmd(4'h4);
        fchk(1'b1, 15'h0400, 32'hFFFFFFFF, 1'b0);
        fchk(1'b0, 15'h0800, 32'hFFFFFFFF, 1'b0);
    endtask
    initial begin
        do_reset();
        s_reset_values();
        s_program_erase();
        s_prog_protect();
        s_read_protect();
        s_commit();
        conclude();
    end
endmodule
`default_nettype wire
